/* tib_engine.sv */
/*
  Command engine for tag identify and multi-block read, with its register
  port, interrupt logic and the request port toward the radio front end.
  Assumes the front end answers each request with one i_tag_done pulse and
  delivers read bytes on i_tag_byte_vld before that pulse.
*/
`default_nettype none
`timescale 1ns/100ps

module tib_engine #(
  parameter int BUF_DEPTH = 256
) (
  input  wire logic        i_clk,          // 100 MHz clock
  input  wire logic        i_rst_n,        // Async reset, active low
  input  wire logic [9:0]  i_addr,         // Register address
  input  wire logic [7:0]  i_wdata,        // Register write data
  input  wire logic        i_wr,           // Write strobe
  input  wire logic        i_rd,           // Read strobe
  output var  logic [7:0]  o_rdata,        // Read data, cycle after strobe
  output var  logic        o_irq,          // Level interrupt
  output var  logic        o_busy,         // Command in progress
  output var  logic        o_tag_req,      // Front-end request pulse
  output var  logic [1:0]  o_tag_op,       // Requested operation
  output var  logic [7:0]  o_tag_blk,      // Absolute block index
  output var  logic [47:0] o_tag_key,      // Sector key, byte 0 in low bits
  output var  logic        o_tag_key_b,    // Use secondary sector key
  input  wire logic        i_tag_done,     // Operation finished pulse
  input  wire logic        i_tag_ok,       // Success / tag present
  input  wire logic [79:0] i_tag_uid,      // Identifier, byte 0 in low bits
  input  wire logic [3:0]  i_tag_uid_len,  // Identifier size in bytes
  input  wire logic [7:0]  i_tag_type,     // Tag type code
  input  wire logic        i_tag_byte_vld, // Read byte strobe
  input  wire logic [7:0]  i_tag_byte      // Read byte
);
  localparam int BAW = $clog2(BUF_DEPTH);

  if (BUF_DEPTH < 16 || BUF_DEPTH > 256 || (1 << BAW) != BUF_DEPTH) begin : g_chk
    $error("BUF_DEPTH must be a power of two from 16 to 256");
  end

  typedef enum logic [1:0] {S_IDLE, S_DET_WAIT, S_AUTH_WAIT, S_RD_WAIT} tib_state_t;

  typedef struct packed {
    tib_state_t             state;
    logic                   busy;
    logic [7:0]             result;
    logic [7:0]             tag_type;
    logic [3:0]             uid_size;
    logic [9:0][7:0]        uid;
    logic [9:0][7:0]        params;
    logic [3:0][5:0][7:0]   keys;
    logic [1:0]             irq_stat;
    logic [1:0]             irq_en;
    logic                   irq;
    logic [7:0]             rdata;
    logic                   sel_buf;
    logic                   tag_ready;
    logic                   tag_req;
    logic [1:0]             tag_op;
    logic [7:0]             tag_blk;
    logic [47:0]            tag_key;
    logic                   tag_key_b;
    logic [7:0]             blk;
    logic [7:0]             left;
    logic [5:0]             auth_sec;
    logic                   auth_vld;
    logic [11:0]            bcnt;
  } tib_regs_t;

  tib_regs_t s, n;
  logic [7:0]     mem_q;
  logic           mem_we;
  logic [BAW-1:0] mem_waddr;
  logic [47:0]    key;
  logic           fin;
  logic [7:0]     fin_code;
  logic [1:0]     ev;
  logic [12:0]    span;
  logic [7:0]     nxt_blk;

  tib_buf_mem #(.DEPTH(BUF_DEPTH)) u_buf (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (i_tag_byte),
    .i_raddr (i_addr[BAW-1:0]),
    .o_rdata (mem_q)
  );

  always_comb begin
    n        = s;
    n.tag_req = 1'b0;
    fin      = 1'b0;
    fin_code = tib_pkg::RES_OK;
    ev       = 2'h0;
    nxt_blk  = 8'(s.blk + 8'h01);
    // Supplied key is stored byte 0 lowest, so the upper param bytes form it directly
    key = s.params[tib_pkg::P_KEYSEL][tib_pkg::KS_SUPPLIED] ? s.params[9:4]
                                                            : s.keys[s.params[3][1:0]];
    span = {5'h00, s.params[tib_pkg::P_OFFSET]} + {1'b0, s.params[tib_pkg::P_COUNT], 4'h0};
    mem_we    = 1'b0;
    mem_waddr = BAW'(s.params[tib_pkg::P_OFFSET] + s.bcnt[7:0]);

    // Register reads: buffer data comes from the memory's own output register
    n.sel_buf = i_rd && i_addr >= tib_pkg::A_BUF;
    if (i_rd) begin
      n.rdata = 8'h00;
      if (i_addr == tib_pkg::A_RESULT) n.rdata = s.result;
      if (i_addr == tib_pkg::A_CMD) n.rdata = {s.busy, 7'h00};
      if (i_addr == tib_pkg::A_TAG_TYPE) n.rdata = s.tag_type;
      if (i_addr == tib_pkg::A_UID_SIZE) n.rdata = {4'h0, s.uid_size};
      if (i_addr == tib_pkg::A_IRQ_STAT) n.rdata = {6'h00, s.irq_stat};
      if (i_addr == tib_pkg::A_IRQ_EN) n.rdata = {6'h00, s.irq_en};
      for (int i = 0; i < tib_pkg::N_PARAM; i++) begin
        if (i_addr == 10'(tib_pkg::A_PARAM + i)) n.rdata = s.params[i];
      end
      for (int i = 0; i < tib_pkg::N_UID; i++) begin
        if (i_addr == 10'(tib_pkg::A_UID + i)) n.rdata = s.uid[i];
      end
    end

    // Register writes; arguments and keys are frozen while a command runs
    if (i_wr) begin
      if (i_addr == tib_pkg::A_IRQ_EN) n.irq_en = i_wdata[1:0];
      for (int i = 0; i < tib_pkg::N_PARAM; i++) begin
        if (!s.busy && i_addr == 10'(tib_pkg::A_PARAM + i)) n.params[i] = i_wdata;
      end
      for (int i = 0; i < tib_pkg::N_KEYSLOT * tib_pkg::KEY_BYTES; i++) begin
        if (!s.busy && i_addr == 10'(tib_pkg::A_KEY + i)) begin
          n.keys[i / tib_pkg::KEY_BYTES][i % tib_pkg::KEY_BYTES] = i_wdata;
        end
      end
    end

    case (s.state)
      S_IDLE: begin
        if (i_wr && i_addr == tib_pkg::A_CMD) begin
          if (i_wdata == tib_pkg::CMD_IDENT) begin
            n.busy    = 1'b1;
            n.tag_req = 1'b1;
            n.tag_op  = tib_pkg::OP_DETECT;
            n.state   = S_DET_WAIT;
          end else if (i_wdata == tib_pkg::CMD_READ) begin
            if (!s.tag_ready) begin
              fin      = 1'b1;
              fin_code = tib_pkg::RES_NOT_INIT;
            end else if (s.params[tib_pkg::P_COUNT] == 8'h00 || span > 13'(BUF_DEPTH)) begin
              fin      = 1'b1;
              fin_code = tib_pkg::RES_ARG;
            end else begin
              n.busy      = 1'b1;
              n.blk       = s.params[tib_pkg::P_START];
              n.left      = s.params[tib_pkg::P_COUNT];
              n.bcnt      = 12'h000;
              n.auth_vld  = 1'b0;
              n.tag_req   = 1'b1;
              n.tag_op    = tib_pkg::OP_AUTH;
              n.tag_blk   = s.params[tib_pkg::P_START];
              n.tag_key   = key;
              n.tag_key_b = s.params[tib_pkg::P_KEYSEL][tib_pkg::KS_SECOND];
              n.state     = S_AUTH_WAIT;
            end
          end else if (i_wdata != tib_pkg::CMD_NONE) begin
            fin      = 1'b1;
            fin_code = tib_pkg::RES_BAD_CMD;
          end
        end
      end
      S_DET_WAIT: begin
        if (i_tag_done) begin
          fin = 1'b1;
          if (i_tag_ok) begin
            n.uid       = i_tag_uid;
            n.tag_type  = i_tag_type;
            n.uid_size  = i_tag_uid_len;
            n.tag_ready = 1'b1;
          end else begin
            n.tag_type = tib_pkg::TYPE_NO_TAG;
            n.uid_size = 4'h0;
            fin_code   = tib_pkg::RES_NO_TAG;
          end
        end
      end
      S_AUTH_WAIT: begin
        if (i_tag_done) begin
          if (i_tag_ok) begin
            n.auth_sec = tib_pkg::sector_of(s.blk);
            n.auth_vld = 1'b1;
            n.tag_req  = 1'b1;
            n.tag_op   = tib_pkg::OP_READ;
            n.tag_blk  = s.blk;
            n.state    = S_RD_WAIT;
          end else begin
            fin      = 1'b1;
            fin_code = tib_pkg::RES_AUTH;
          end
        end
      end
      S_RD_WAIT: begin
        if (i_tag_byte_vld) begin
          mem_we = 1'b1;
          n.bcnt = 12'(s.bcnt + 12'h001);
        end
        if (i_tag_done) begin
          if (!i_tag_ok) begin
            fin      = 1'b1;
            fin_code = tib_pkg::RES_READ;
          end else if (s.left > 8'h01) begin
            n.left    = 8'(s.left - 8'h01);
            n.blk     = nxt_blk;
            n.tag_req = 1'b1;
            n.tag_blk = nxt_blk;
            if (tib_pkg::sector_of(nxt_blk) != s.auth_sec) begin
              n.tag_op = tib_pkg::OP_AUTH;
              n.state  = S_AUTH_WAIT;
            end else begin
              n.tag_op = tib_pkg::OP_READ;
            end
          end else begin
            fin = 1'b1;
          end
        end
      end
      default: n.state = S_IDLE;
    endcase

    if (fin) begin
      n.result = fin_code;
      n.busy   = 1'b0;
      n.state  = S_IDLE;
      ev[tib_pkg::EV_DONE] = 1'b1;
      ev[tib_pkg::EV_ERR]  = fin_code != tib_pkg::RES_OK;
      // A failed operation leaves the tag in an unknown state, so demand a new identify
      if (fin_code != tib_pkg::RES_OK) n.tag_ready = 1'b0;
    end

    // A new event wins over a clear written in the same cycle
    if (i_wr && i_addr == tib_pkg::A_IRQ_CLR) n.irq_stat = n.irq_stat & ~i_wdata[1:0];
    n.irq_stat = n.irq_stat | ev;
    n.irq      = |(n.irq_stat & n.irq_en);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_rdata     = s.sel_buf ? mem_q : s.rdata;
  assign o_irq       = s.irq;
  assign o_busy      = s.busy;
  assign o_tag_req   = s.tag_req;
  assign o_tag_op    = s.tag_op;
  assign o_tag_blk   = s.tag_blk;
  assign o_tag_key   = s.tag_key;
  assign o_tag_key_b = s.tag_key_b;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic ident_go;
  logic read_go;
  assign ident_go = s.state == S_IDLE && i_wr && i_addr == tib_pkg::A_CMD
                    && i_wdata == tib_pkg::CMD_IDENT;
  assign read_go  = s.state == S_IDLE && n.state == S_AUTH_WAIT;

  property p_det_first;
    ident_go |=> o_tag_req && o_tag_op == tib_pkg::OP_DETECT ##1 !o_tag_req && o_busy;
  endproperty
  a_det_first: assert property (p_det_first) else $error("identify did not probe first");

  property p_no_tag;
    (s.state == S_DET_WAIT && i_tag_done && !i_tag_ok)
      |=> s.tag_type == tib_pkg::TYPE_NO_TAG && s.result == tib_pkg::RES_NO_TAG;
  endproperty
  a_no_tag: assert property (p_no_tag) else $error("no-tag code not loaded");

  property p_found;
    (s.state == S_DET_WAIT && i_tag_done && i_tag_ok)
      |=> s.uid == $past(i_tag_uid) && s.uid_size == $past(i_tag_uid_len)
          && s.tag_type == $past(i_tag_type) && s.result == tib_pkg::RES_OK;
  endproperty
  a_found: assert property (p_found) else $error("identify results not stored");

  property p_start_blk;
    read_go |=> o_tag_req && o_tag_op == tib_pkg::OP_AUTH
                && o_tag_blk == $past(s.params[tib_pkg::P_START]);
  endproperty
  a_start_blk: assert property (p_start_blk) else $error("wrong first block");

  property p_next_blk;
    (s.state == S_RD_WAIT && i_tag_done && i_tag_ok && s.left > 8'h01)
      |=> o_tag_req && o_tag_blk == 8'($past(s.blk) + 8'h01);
  endproperty
  a_next_blk: assert property (p_next_blk) else $error("run did not continue");

  property p_key_sel;
    (o_tag_req && o_tag_op == tib_pkg::OP_AUTH && s.params[3][6])
      |-> o_tag_key == s.params[9:4] && o_tag_key_b == s.params[3][7];
  endproperty
  a_key_sel: assert property (p_key_sel) else $error("supplied key not used");

  property p_key_slot;
    (o_tag_req && o_tag_op == tib_pkg::OP_AUTH && !s.params[3][6])
      |-> o_tag_key == s.keys[s.params[3][1:0]];
  endproperty
  a_key_slot: assert property (p_key_slot) else $error("slot key not used");

  property p_auth_before_read;
    (o_tag_req && o_tag_op == tib_pkg::OP_READ)
      |-> s.auth_vld && s.auth_sec == tib_pkg::sector_of(o_tag_blk);
  endproperty
  a_auth_before_read: assert property (p_auth_before_read) else $error("read unauth");

  property p_auth_fail;
    (s.state == S_AUTH_WAIT && i_tag_done && !i_tag_ok)
      |=> s.result == tib_pkg::RES_AUTH && !o_busy ##1 !o_tag_req;
  endproperty
  a_auth_fail: assert property (p_auth_fail) else $error("auth failure not ended");

  property p_new_sector;
    (s.state == S_RD_WAIT && i_tag_done && i_tag_ok && s.left > 8'h01
     && tib_pkg::sector_of(nxt_blk) != s.auth_sec) |=> o_tag_op == tib_pkg::OP_AUTH;
  endproperty
  a_new_sector: assert property (p_new_sector) else $error("new sector not authed");

  property p_read_ok;
    (s.state == S_RD_WAIT && i_tag_done && i_tag_ok && s.left == 8'h01)
      |=> s.result == tib_pkg::RES_OK && s.irq_stat[tib_pkg::EV_DONE] && !o_busy;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("success not reported");

  property p_read_fail;
    (s.state == S_RD_WAIT && i_tag_done && !i_tag_ok) |=> s.result == tib_pkg::RES_READ;
  endproperty
  a_read_fail: assert property (p_read_fail) else $error("read error not stored");

  property p_done_evt;
    $fell(o_busy) |-> s.irq_stat[tib_pkg::EV_DONE] && s.state == S_IDLE;
  endproperty
  a_done_evt: assert property (p_done_evt) else $error("completion not flagged");
endmodule // tib_engine

`default_nettype wire

/* tib_pkg.sv */
/*
  Shared constants for the tag identify and block read engine: register
  offsets, command codes, result codes, tag operations and sizes.
  Assumes a byte-wide register port with a 10-bit address.
*/
`default_nettype none

package tib_pkg;
  localparam int AW = 10;

  // Register offsets
  localparam logic [9:0] A_RESULT   = 10'h000;
  localparam logic [9:0] A_CMD      = 10'h001;
  localparam logic [9:0] A_TAG_TYPE = 10'h002;
  localparam logic [9:0] A_UID_SIZE = 10'h003;
  localparam logic [9:0] A_IRQ_STAT = 10'h004;
  localparam logic [9:0] A_IRQ_CLR  = 10'h005;
  localparam logic [9:0] A_IRQ_EN   = 10'h006;
  localparam logic [9:0] A_PARAM    = 10'h010;
  localparam logic [9:0] A_UID      = 10'h020;
  localparam logic [9:0] A_KEY      = 10'h040;
  localparam logic [9:0] A_BUF      = 10'h200;

  localparam int N_PARAM   = 10;
  localparam int N_UID     = 10;
  localparam int N_KEYSLOT = 4;
  localparam int KEY_BYTES = 6;
  localparam int BLK_BYTES = 16;

  // Argument byte positions of the block read command
  localparam int P_START  = 0;
  localparam int P_COUNT  = 1;
  localparam int P_OFFSET = 2;
  localparam int P_KEYSEL = 3;
  localparam int KS_SUPPLIED = 6;
  localparam int KS_SECOND   = 7;

  // Command codes
  localparam logic [7:0] CMD_NONE  = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h01;
  localparam logic [7:0] CMD_READ  = 8'h02;

  // Result codes
  localparam logic [7:0] RES_OK       = 8'h00;
  localparam logic [7:0] RES_NO_TAG   = 8'h01;
  localparam logic [7:0] RES_AUTH     = 8'h02;
  localparam logic [7:0] RES_READ     = 8'h03;
  localparam logic [7:0] RES_ARG      = 8'h04;
  localparam logic [7:0] RES_NOT_INIT = 8'h05;
  localparam logic [7:0] RES_BAD_CMD  = 8'h06;

  localparam logic [7:0] TYPE_NO_TAG = 8'h00;

  // Front-end operations
  localparam logic [1:0] OP_DETECT = 2'h0;
  localparam logic [1:0] OP_AUTH   = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;

  // Interrupt status bits
  localparam int EV_DONE = 0;
  localparam int EV_ERR  = 1;

  // Small sectors of 4 blocks below block 128, large sectors of 16 above
  function automatic logic [5:0] sector_of(input logic [7:0] blk);
    if (blk[7]) begin
      sector_of = 6'h20 + {2'h0, blk[6:4]};
    end else begin
      sector_of = blk[7:2];
    end
  endfunction
endpackage

`default_nettype wire

/* tib_buf_mem.sv */
/*
  Byte-wide data buffer with one write port and one registered read port.
  Assumes both ports run on i_clk; writer and reader never need ordering.
*/
`default_nettype none
`timescale 1ns/100ps

module tib_buf_mem #(
  parameter int DEPTH = 256
) (
  input  wire logic                     i_clk,    // System clock
  input  wire logic                     i_we,     // Write enable
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,  // Write address
  input  wire logic [7:0]               i_wdata,  // Write data
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,  // Read address
  output var  logic [7:0]               o_rdata   // Registered read data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // tib_buf_mem

`default_nettype wire

/* tib_tag_model.sv */
/*
  Behavioural radio front end for the tag engine bench.
  Assumes one request at a time, each answered by a done pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module tib_tag_model (
  input  wire logic        i_clk,      // Clock
  input  wire logic        i_req,      // Request pulse
  input  wire logic [1:0]  i_op,       // Operation
  input  wire logic [7:0]  i_blk,      // Block index
  input  wire logic [47:0] i_key,      // Key offered
  input  wire logic        i_key_b,    // Secondary key offered
  input  wire logic        i_present,  // Tag in field
  input  wire logic [47:0] i_good_key, // Key the tag accepts
  input  wire logic        i_good_b,   // Key kind the tag accepts
  input  wire logic        i_rd_fail,  // Tag memory unreadable
  input  wire logic [3:0]  i_lat,      // Answer delay in cycles
  output var  logic        o_done,     // Done pulse
  output var  logic        o_ok,       // Success
  output var  logic        o_vld,      // Byte strobe
  output var  logic [7:0]  o_byte,     // Read byte
  output var  logic [7:0]  o_nauth,    // Authentications seen
  output var  logic [7:0]  o_nread     // Block reads seen
);
  logic [7:0] sec_r;
  logic       ok;
  int         k;

  function automatic logic [7:0] sec(input logic [7:0] b);
    return b[7] ? 8'h20 + 8'(b[6:4]) : 8'(b[7:2]);
  endfunction

  initial begin
    o_done = 1'b0;
    o_ok = 1'b0;
    o_vld = 1'b0;
    o_byte = 8'h00;
    o_nauth = 8'h00;
    o_nread = 8'h00;
    sec_r = 8'hff;
    forever begin
      @(posedge i_clk);
      if (i_req === 1'b1) begin
        repeat (i_lat) @(posedge i_clk);
        ok = i_present;
        if (i_op == 2'h1) begin
          o_nauth <= o_nauth + 8'h01;
          ok = i_present && i_key == i_good_key && i_key_b == i_good_b;
          sec_r = ok ? sec(i_blk) : 8'hff;
        end else if (i_op == 2'h2) begin
          o_nread <= o_nread + 8'h01;
          // A real tag refuses a block whose sector was not opened
          ok = sec(i_blk) == sec_r && !i_rd_fail;
          for (k = 0; k < 16 && ok; k++) begin
            o_vld <= 1'b1;
            o_byte <= i_blk + 8'(k);
            @(posedge i_clk);
          end
          o_vld <= 1'b0;
          o_byte <= ~o_byte;
        end else begin
          sec_r = 8'hff;
        end
        o_done <= 1'b1;
        o_ok <= ok;
        @(posedge i_clk);
        o_done <= 1'b0;
        o_ok <= ~ok;
      end
    end
  end
endmodule // tib_tag_model

`default_nettype wire

/* tb_tag_identify_and_block_read.sv */
/*
  Self-checking bench for the tag identify and block read engine.
  Assumes tib_tag_model as front end and the default buffer depth.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_tag_identify_and_block_read;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [9:0]  i_addr = 10'h000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [79:0] i_tag_uid = '0;
  logic [3:0]  i_tag_uid_len = 4'h0;
  logic [7:0]  i_tag_type = 8'h00;
  logic        present = 1'b0;
  logic        rd_fail = 1'b0;
  logic        good_b = 1'b0;
  logic [47:0] good_key = '0;
  logic [3:0]  lat = 4'h0;
  logic [7:0]  o_rdata, o_tag_blk, t_byte, nauth, nread;
  logic        o_irq, o_busy, o_tag_req, o_tag_key_b, t_done, t_ok, t_vld;
  logic [1:0]  o_tag_op, last_op;
  logic [47:0] o_tag_key;
  logic [47:0] slot [4];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 32'h9d67f484;

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_tag_req === 1'b1) last_op <= o_tag_op;

  tib_engine dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_busy(o_busy),
    .o_tag_req(o_tag_req), .o_tag_op(o_tag_op), .o_tag_blk(o_tag_blk), .o_tag_key(o_tag_key),
    .o_tag_key_b(o_tag_key_b), .i_tag_done(t_done), .i_tag_ok(t_ok), .i_tag_uid(i_tag_uid),
    .i_tag_uid_len(i_tag_uid_len), .i_tag_type(i_tag_type), .i_tag_byte_vld(t_vld),
    .i_tag_byte(t_byte));
  tib_tag_model fe (.i_clk(i_clk), .i_req(o_tag_req), .i_op(o_tag_op), .i_blk(o_tag_blk),
    .i_key(o_tag_key), .i_key_b(o_tag_key_b), .i_present(present), .i_good_key(good_key),
    .i_good_b(good_b), .i_rd_fail(rd_fail), .i_lat(lat), .o_done(t_done), .o_ok(t_ok),
    .o_vld(t_vld), .o_byte(t_byte), .o_nauth(nauth), .o_nread(nread));

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rc(input logic [9:0] a, input logic [7:0] e, input string nm);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(nm, o_rdata, e);
  endtask

  task automatic run(input logic [7:0] c);
    int n;
    wr(tib_pkg::A_CMD, c);
    #1 n = 0;
    while (o_busy === 1'b1 && n < 2000) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 2000) mismatches++;
  endtask

  function automatic logic [7:0] sec(input logic [7:0] b);
    return b[7] ? 8'h20 + 8'(b[6:4]) : 8'(b[7:2]);
  endfunction

  task automatic ident(input logic pr);
    int k;
    @(posedge i_clk);
    present <= pr;
    i_tag_uid <= {$random(seed), $random(seed), 16'($random(seed))};
    i_tag_uid_len <= 4'(1 + {$random(seed)} % 10);
    i_tag_type <= 8'($random(seed)) | 8'h01;
    lat <= 4'($random(seed));
    run(tib_pkg::CMD_IDENT);
    chk("first op", 8'(last_op), 8'(tib_pkg::OP_DETECT));
    rc(tib_pkg::A_RESULT, pr ? tib_pkg::RES_OK : tib_pkg::RES_NO_TAG, "result");
    rc(tib_pkg::A_TAG_TYPE, pr ? i_tag_type : tib_pkg::TYPE_NO_TAG, "type");
    if (pr) begin
      rc(tib_pkg::A_UID_SIZE, 8'(i_tag_uid_len), "uid size");
      for (k = 0; k < i_tag_uid_len; k++)
        rc(10'(tib_pkg::A_UID + k), i_tag_uid[8*k+:8], "uid");
    end
  endtask

  // Mode 0 clean, 1 wrong key, 2 unreadable memory
  task automatic do_read(input logic [7:0] st, cn, of, ks, input logic [47:0] key, input int md);
    logic [7:0] na, nr, ex;
    int         i, k;
    wr(tib_pkg::A_PARAM, st);
    wr(10'(tib_pkg::A_PARAM + 1), cn);
    wr(10'(tib_pkg::A_PARAM + 2), of);
    wr(10'(tib_pkg::A_PARAM + 3), ks);
    for (i = 0; i < 6; i++) wr(10'(tib_pkg::A_PARAM + 4 + i), key[8*i+:8]);
    good_key <= (ks[6] ? key : slot[ks[1:0]]) ^ {48{md == 1}};
    good_b <= ks[7];
    rd_fail <= (md == 2);
    lat <= 4'($random(seed));
    na = nauth;
    nr = nread;
    ex = 8'h01;
    for (i = 1; i < cn; i++) if (sec(st + 8'(i)) != sec(st + 8'(i - 1))) ex++;
    run(tib_pkg::CMD_READ);
    rc(tib_pkg::A_RESULT, md == 0 ? tib_pkg::RES_OK : md == 1 ? tib_pkg::RES_AUTH :
       tib_pkg::RES_READ, "result");
    if (md == 1) chk("reads after failed auth", nread - nr, 8'h00);
    if (md == 0) begin
      chk("auths", nauth - na, ex);
      for (i = 0; i < cn; i++) for (k = 0; k < 16; k++)
        rc(10'(tib_pkg::A_BUF + of + 16 * i + k), st + 8'(i + k), "buffer");
    end
    rd_fail <= 1'b0;
  endtask

  initial begin
    logic [7:0] cn;
    int         r, s, j;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1 chk("irq after reset", 8'(o_irq), 8'h00);
    for (s = 0; s < 4; s++) begin
      slot[s] = {$random(seed), 16'($random(seed))};
      for (j = 0; j < 6; j++) wr(10'(tib_pkg::A_KEY + 6 * s + j), slot[s][8*j+:8]);
    end
    wr(10'(tib_pkg::A_PARAM + 1), 8'h01);
    run(tib_pkg::CMD_READ);
    rc(tib_pkg::A_RESULT, tib_pkg::RES_NOT_INIT, "read before identify");
    ident(1'b0);
    wr(tib_pkg::A_IRQ_CLR, 8'h03);
    wr(tib_pkg::A_IRQ_EN, 8'h01);
    ident(1'b1);
    chk("irq on done", 8'(o_irq), 8'h01);
    rc(tib_pkg::A_IRQ_STAT, 8'h01, "irq status");
    wr(tib_pkg::A_IRQ_CLR, 8'h01);
    rc(tib_pkg::A_IRQ_STAT, 8'h00, "irq status cleared");
    chk("irq cleared", 8'(o_irq), 8'h00);
    wr(tib_pkg::A_IRQ_EN, 8'h00);
    ident(1'b1);
    chk("irq masked", 8'(o_irq), 8'h00);
    wr(tib_pkg::A_IRQ_EN, 8'h01);
    rc(tib_pkg::A_IRQ_STAT, 8'h01, "irq status masked");
    chk("irq unmasked", 8'(o_irq), 8'h01);
    wr(tib_pkg::A_IRQ_CLR, 8'h03);
    // Crosses from the last small sector into the first large one at the top offset
    do_read(8'd126, 8'd3, 8'd208, 8'h40, {$random(seed), 16'($random(seed))}, 0);
    for (r = 0; r < 8; r++) begin
      cn = 8'(1 + {$random(seed)} % 3);
      do_read(8'($random(seed)), cn, 8'({$random(seed)} % (257 - 16 * cn)),
              8'($random(seed)) & 8'hc3, {$random(seed), 16'($random(seed))}, 0);
    end
    do_read(8'd4, 8'd2, 8'd0, 8'h81, '0, 1);
    run(tib_pkg::CMD_READ);
    rc(tib_pkg::A_RESULT, tib_pkg::RES_NOT_INIT, "read after error");
    ident(1'b1);
    do_read(8'd200, 8'd2, 8'd16, 8'hc0, {$random(seed), 16'($random(seed))}, 2);
    ident(1'b1);
    // Long answer delay keeps the engine busy across the readback and the refused write
    lat <= 4'hf;
    wr(tib_pkg::A_CMD, tib_pkg::CMD_IDENT);
    rc(tib_pkg::A_CMD, 8'h80, "busy readback");
    wr(tib_pkg::A_PARAM, 8'h55);
    run(tib_pkg::CMD_NONE);
    rc(tib_pkg::A_PARAM, 8'd200, "start frozen while busy");
    rc(tib_pkg::A_CMD, 8'h00, "idle readback");
    wr(10'(tib_pkg::A_PARAM + 1), 8'h00);
    run(tib_pkg::CMD_READ);
    rc(tib_pkg::A_RESULT, tib_pkg::RES_ARG, "zero count");
    run(8'h07);
    rc(tib_pkg::A_RESULT, tib_pkg::RES_BAD_CMD, "unknown command");
    end_sim;
  end

  initial begin
    // The whole run needs well under ten thousand cycles; this allows twenty thousand
    #200000;
    mismatches++;
    end_sim;
  end
endmodule // tb_tag_identify_and_block_read

`default_nettype wire
